// ===== rtl/dpo_map.svh
`ifndef DPO_MAP_SVH
`define DPO_MAP_SVH
`define DPO_IDX_BRAKE 16'h2045
`define DPO_IDX_DRAG 16'h2046
`define DPO_IDX_READJ 16'h2047
`define DPO_IDX_LINK 16'h2049
`define DPO_IDX_FBPOS 16'h204a
`define DPO_IDX_RETRY 16'h204b
`define DPO_IDX_MODEL 16'h204d
`define DPO_IDX_FWREV 16'h204e
`define DPO_IDX_STORE 16'h204f
`define DPO_IDX_CTRL 16'h2024
`define DPO_RST_BRAKE 16'h03e8
`define DPO_RST_DRAG 16'h0004
`define DPO_RST_READJ 8'h00
`define DPO_RST_LINK 16'h0001
`define DPO_RST_FBPOS 32'h00000000
`define DPO_RST_RETRY 16'h0000
`define DPO_MAX_BRAKE 16'h0bb8
`define DPO_MAX_DRAG 16'h000a
`define DPO_CMD_RESET 16'hfffa
`define DPO_CMD_FACT_SAVE_MID 16'hfffb
`define DPO_CMD_USER_MID 16'hfffc
`define DPO_CMD_FACT_SAVE 16'hfffd
`define DPO_CMD_USER 16'hfffe
`define DPO_CMD_FACT 16'hffff
`define DPO_CMD_SAVE 16'h0001
`define DPO_CTRL_STALE 16'h0014
`define DPO_CLK_HZ 40000000
`define DPO_MS_CYC (`DPO_CLK_HZ / 1000)
`define DPO_SEC_CYC `DPO_CLK_HZ
`define DPO_BOOT_S1 15
`define DPO_BOOT_S2 30
`define DPO_BOOT_S3 60
`endif

// ===== rtl/dpo_pkg.sv
package dpo_pkg;
   typedef enum logic [1:0] {
      DPO_ST_IDLE = 2'b00,
      DPO_ST_BUSY = 2'b01,
      DPO_ST_DONE = 2'b11
   } dpo_nv_t;
   typedef enum logic [1:0] {
      DPO_LL_HOLD = 2'b00,
      DPO_LL_ABORT = 2'b01,
      DPO_LL_SAFE = 2'b10,
      DPO_LL_RSVD = 2'b11
   } dpo_ll_t;
   typedef logic [15:0] dpo_idx_t;
endpackage

// ===== rtl/dpo_objects.sv
`include "dpo_map.svh"
`timescale 1ns/10ps
`default_nettype none
module dpo_objects #(
   parameter int unsigned MS_CYC = `DPO_MS_CYC,
   parameter int unsigned SEC_CYC = `DPO_SEC_CYC
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire dpo_pkg::dpo_idx_t idx_in,
   input wire logic [31:0] wdata_in,
   output logic [31:0] rdata_out,
   output logic ack_out,
   output logic abort_out,
   input wire logic standstill_in,
   input wire logic run_end_in,
   input wire logic link_up_in,
   input wire logic link_lost_in,
   input wire logic op_state_in,
   input wire logic [15:0] pdo_ctrl_in,
   input wire logic safe_fail_in,
   input wire logic nv_done_in,
   input wire logic nv_err_in,
   input wire logic nv_boot_bad_in,
   output logic brake_release_out,
   output logic [15:0] drag_limit_out,
   output logic readjust_out,
   output logic abort_run_out,
   output logic safe_run_out,
   output logic [31:0] safe_target_out,
   output logic mid_run_out,
   output logic mid_run_measure_out,
   output logic drive_reset_out,
   output logic nv_save_out,
   output logic load_factory_out,
   output logic load_user_out,
   output logic drop_pending_out
);
   import dpo_pkg::*;

   localparam logic [31:0] MODEL_STR = 32'h4d4f4430; // Arbitrary model text
   localparam logic [15:0] FW_REV = 16'h0100; // Arbitrary revision

   // ******************
   // Registers
   // ******************
   logic [15:0] brake_q, drag_q, link_q, retry_q, cmd_stat_q, ctrl_q;
   logic [7:0] readj_q;
   logic [31:0] fbpos_q;
   dpo_nv_t nv_q;

   wire [15:0] w16 = wdata_in[15:0];
   wire hit_brake = idx_in == `DPO_IDX_BRAKE;
   wire hit_drag = idx_in == `DPO_IDX_DRAG;
   wire hit_readj = idx_in == `DPO_IDX_READJ;
   wire hit_link = idx_in == `DPO_IDX_LINK;
   wire hit_fbpos = idx_in == `DPO_IDX_FBPOS;
   wire hit_retry = idx_in == `DPO_IDX_RETRY;
   wire hit_model = idx_in == `DPO_IDX_MODEL;
   wire hit_fwrev = idx_in == `DPO_IDX_FWREV;
   wire hit_store = idx_in == `DPO_IDX_STORE;
   wire hit_ctrl = idx_in == `DPO_IDX_CTRL;
   wire cmd_known = w16 == `DPO_CMD_RESET || w16 == `DPO_CMD_FACT_SAVE_MID ||
      w16 == `DPO_CMD_USER_MID || w16 == `DPO_CMD_FACT_SAVE || w16 == `DPO_CMD_USER ||
      w16 == `DPO_CMD_FACT || w16 == `DPO_CMD_SAVE;
   // Signed 31-bit value: top two bits must agree
   wire fb_ok = wdata_in[31] == wdata_in[30];
   wire bad_brake = hit_brake && w16 > `DPO_MAX_BRAKE;
   wire bad_drag = hit_drag && (w16 > `DPO_MAX_DRAG || !standstill_in);
   wire bad_readj = hit_readj && wdata_in[7:1] != 7'h00;
   wire bad_link = hit_link && w16[1:0] == DPO_LL_RSVD;
   wire bad_fbpos = hit_fbpos && !fb_ok;
   wire bad_store = hit_store && (!cmd_known || !standstill_in);
   wire ro_hit = hit_model || hit_fwrev;
   wire known = hit_brake || hit_drag || hit_readj || hit_link || hit_fbpos ||
      hit_retry || ro_hit || hit_store || hit_ctrl;
   wire wr_bad = !known || ro_hit || bad_brake || bad_drag || bad_readj ||
      bad_link || bad_fbpos || bad_store;
   wire wr_ok = wr_en_in && !wr_bad;
   wire cmd_wr = wr_ok && hit_store;
   wire is_fact = cmd_wr && (w16 == `DPO_CMD_FACT || w16 == `DPO_CMD_FACT_SAVE ||
      w16 == `DPO_CMD_FACT_SAVE_MID);
   wire is_user = cmd_wr && (w16 == `DPO_CMD_USER || w16 == `DPO_CMD_USER_MID);
   wire is_save = cmd_wr && (w16 == `DPO_CMD_SAVE || w16 == `DPO_CMD_FACT_SAVE ||
      w16 == `DPO_CMD_FACT_SAVE_MID);
   wire is_mid = cmd_wr && (w16 == `DPO_CMD_FACT_SAVE_MID || w16 == `DPO_CMD_USER_MID);
   logic mid_q, mid_meas_q, mid_pend_q;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         brake_q <= `DPO_RST_BRAKE;
         drag_q <= `DPO_RST_DRAG;
         readj_q <= `DPO_RST_READJ;
         link_q <= `DPO_RST_LINK;
         fbpos_q <= `DPO_RST_FBPOS;
         retry_q <= `DPO_RST_RETRY;
      end else if (is_fact) begin
         brake_q <= `DPO_RST_BRAKE;
         drag_q <= `DPO_RST_DRAG;
         readj_q <= `DPO_RST_READJ;
         link_q <= `DPO_RST_LINK;
         fbpos_q <= `DPO_RST_FBPOS;
         retry_q <= `DPO_RST_RETRY;
      end else if (wr_ok) begin
         if (hit_brake) brake_q <= w16;
         if (hit_drag) drag_q <= w16;
         if (hit_readj) readj_q <= wdata_in[7:0];
         if (hit_link) link_q <= w16;
         if (hit_fbpos) fbpos_q <= wdata_in;
         if (hit_retry) retry_q <= w16;
      end
   end
   // User restore is carried out by the memory side on load_user_out.

   // ******************
   // Bus answer
   // ******************
   logic [31:0] rd_d;
   always_comb begin
      rd_d = 32'h00000000;
      if (hit_brake) rd_d = {16'h0000, brake_q};
      if (hit_drag) rd_d = {16'h0000, drag_q};
      if (hit_readj) rd_d = {24'h000000, readj_q};
      if (hit_link) rd_d = {16'h0000, link_q};
      if (hit_fbpos) rd_d = fbpos_q;
      if (hit_retry) rd_d = {16'h0000, retry_q};
      if (hit_model) rd_d = MODEL_STR;
      if (hit_fwrev) rd_d = {16'h0000, FW_REV};
      if (hit_store) rd_d = {16'h0000, cmd_stat_q};
      if (hit_ctrl) rd_d = {16'h0000, ctrl_q};
   end
   wire rd_bad = rd_en_in && !known;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_out <= 32'h00000000;
         ack_out <= 1'b0;
         abort_out <= 1'b0;
      end else begin
         rdata_out <= rd_en_in ? rd_d : rdata_out;
         ack_out <= (wr_en_in && !wr_bad) || (rd_en_in && known);
         abort_out <= (wr_en_in && wr_bad) || rd_bad;
      end
   end

   // ******************
   // Store command
   // ******************
   logic boot_seen_q;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         nv_q <= DPO_ST_IDLE;
         cmd_stat_q <= 16'h0001;
         boot_seen_q <= 1'b0;
      end else begin
         boot_seen_q <= 1'b1;
         if (!boot_seen_q) cmd_stat_q <= {15'h0000, nv_boot_bad_in};
         unique case (nv_q)
            DPO_ST_IDLE: if (is_save) begin
               nv_q <= DPO_ST_BUSY;
               cmd_stat_q <= 16'h0001;
            end
            DPO_ST_BUSY: if (nv_done_in || nv_err_in) begin
               nv_q <= DPO_ST_DONE;
               cmd_stat_q <= {14'h0000, nv_err_in, 1'b0};
            end
            DPO_ST_DONE: nv_q <= DPO_ST_IDLE;
         endcase
      end
   end
   assign nv_save_out = is_save && nv_q == DPO_ST_IDLE;
   assign load_factory_out = is_fact;
   assign load_user_out = is_user;
   assign drive_reset_out = cmd_wr && w16 == `DPO_CMD_RESET;

   // ******************
   // Mid-range run
   // ******************
   wire ctrl_wr = wr_ok && hit_ctrl;
   logic [15:0] pdo_last_q;
   wire pdo_chg = op_state_in && pdo_ctrl_in != pdo_last_q;
   wire mid_abort = (ctrl_wr && w16 == 16'h0000) || pdo_chg;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         mid_q <= 1'b0;
         mid_meas_q <= 1'b0;
         mid_pend_q <= 1'b0;
         ctrl_q <= 16'h0000;
         pdo_last_q <= 16'h0000;
      end else begin
         pdo_last_q <= pdo_ctrl_in;
         if (ctrl_wr) ctrl_q <= w16;
         // Mid run start waits for a save to end
         if (is_mid) begin
            mid_pend_q <= 1'b1;
            mid_meas_q <= w16 == `DPO_CMD_FACT_SAVE_MID;
         end else if (mid_pend_q && nv_q != DPO_ST_BUSY) begin
            mid_pend_q <= 1'b0;
            mid_q <= 1'b1;
         end else if (mid_q && (mid_abort || run_end_in)) begin
            mid_q <= 1'b0;
         end
      end
   end
   assign mid_run_out = mid_q;
   assign mid_run_measure_out = mid_meas_q;
   // Old stale 0x14 command must not relaunch after mid run
   assign drop_pending_out = mid_q || (pdo_ctrl_in == `DPO_CTRL_STALE && !pdo_chg);

   // ******************
   // Brake hold-off
   // ******************
   logic [31:0] ms_q;
   logic [15:0] brk_cnt_q;
   logic brk_q;
   wire ms_tick = ms_q == MS_CYC - 1;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ms_q <= 32'h00000000;
         brk_cnt_q <= 16'h0000;
         brk_q <= 1'b0;
      end else begin
         // Prescaler restarts at run end, so hold-off is never cut short
         ms_q <= (ms_tick || run_end_in) ? 32'h00000000 : ms_q + 32'h00000001;
         if (run_end_in) begin
            brk_q <= brake_q != 16'h0000;
            brk_cnt_q <= brake_q;
         end else if (brk_q && ms_tick) begin
            brk_cnt_q <= brk_cnt_q - 16'h0001;
            if (brk_cnt_q == 16'h0001) brk_q <= 1'b0;
         end
      end
   end
   assign brake_release_out = brk_q;
   assign drag_limit_out = drag_q;
   assign readjust_out = readj_q[0];

   // ******************
   // Link loss and safe run
   // ******************
   logic [31:0] sec_q;
   logic [15:0] boot_s_q, retry_cnt_q;
   logic connected_q, boot_done_q, retry_q2;
   wire sec_tick = sec_q == SEC_CYC - 1;
   logic [15:0] boot_lim;
   always_comb begin
      unique case (link_q[3:2])
         2'b01: boot_lim = 16'(`DPO_BOOT_S1);
         2'b10: boot_lim = 16'(`DPO_BOOT_S2);
         2'b11: boot_lim = 16'(`DPO_BOOT_S3);
         default: boot_lim = 16'h0000;
      endcase
   end
   wire boot_fire = !connected_q && !boot_done_q && link_q[3:2] != 2'b00 &&
      sec_tick && boot_s_q + 16'h0001 >= boot_lim;
   wire loss_safe = link_lost_in && connected_q && link_q[1:0] == DPO_LL_SAFE;
   wire retry_fire = retry_q2 && sec_tick && retry_cnt_q + 16'h0001 >= retry_q;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sec_q <= 32'h00000000;
         boot_s_q <= 16'h0000;
         retry_cnt_q <= 16'h0000;
         connected_q <= 1'b0;
         boot_done_q <= 1'b0;
         retry_q2 <= 1'b0;
      end else begin
         sec_q <= sec_tick ? 32'h00000000 : sec_q + 32'h00000001;
         if (link_up_in) connected_q <= 1'b1;
         if (link_up_in || boot_fire) boot_done_q <= 1'b1;
         if (sec_tick && !boot_done_q) boot_s_q <= boot_s_q + 16'h0001;
         if (safe_fail_in && retry_q != 16'h0000) begin
            retry_q2 <= 1'b1;
            retry_cnt_q <= 16'h0000;
         end else if (retry_fire) begin
            retry_q2 <= 1'b0;
         end else if (retry_q2 && sec_tick) begin
            retry_cnt_q <= retry_cnt_q + 16'h0001;
         end
      end
   end
   assign abort_run_out = link_lost_in && connected_q && link_q[1:0] == DPO_LL_ABORT;
   assign safe_run_out = loss_safe || boot_fire || retry_fire;
   assign safe_target_out = fbpos_q;

   // ******************
   // Checks
   // ******************
   a_bad_write_abort: assert property (@(posedge clk_in) disable iff (rst_in)
      wr_en_in && wr_bad |=> abort_out && !ack_out) else $error("bad write not aborted");
   a_drag_moving: assert property (@(posedge clk_in) disable iff (rst_in)
      wr_en_in && hit_drag && !standstill_in |=> $stable(drag_q)) else $error("drag changed moving");
   a_cmd_moving: assert property (@(posedge clk_in) disable iff (rst_in)
      wr_en_in && hit_store && !standstill_in |-> !nv_save_out && !drive_reset_out)
      else $error("command taken moving");
   a_save_busy: assert property (@(posedge clk_in) disable iff (rst_in)
      nv_save_out |=> cmd_stat_q != 16'h0000) else $error("save status zero while busy");
   a_fact_value: assert property (@(posedge clk_in) disable iff (rst_in)
      is_fact |=> brake_q == `DPO_RST_BRAKE && drag_q == `DPO_RST_DRAG) else $error("factory load wrong");
   a_mid_abort: assert property (@(posedge clk_in) disable iff (rst_in)
      mid_q && ctrl_wr && w16 == 16'h0000 && !is_mid && !mid_pend_q |=> !mid_q) else $error("mid run not aborted");
   a_safe_target: assert property (@(posedge clk_in) disable iff (rst_in)
      safe_run_out |-> safe_target_out == fbpos_q) else $error("safe target wrong");
   a_brake_hold: assert property (@(posedge clk_in) disable iff (rst_in)
      run_end_in && brake_q != 16'h0000 |=> brake_release_out [*2]) else $error("brake not held");
   a_reset_cmd: assert property (@(posedge clk_in) disable iff (rst_in)
      cmd_wr && w16 == `DPO_CMD_RESET |-> drive_reset_out && !nv_save_out) else $error("reset cmd lost");
   a_ack_abort_excl: assert property (@(posedge clk_in) disable iff (rst_in)
      !(ack_out && abort_out))
      else $error("ack and abort together");
   a_model_read: assert property (@(posedge clk_in) disable iff (rst_in)
      rd_en_in && hit_model |=> rdata_out == MODEL_STR && ack_out)
      else $error("model read wrong");
   a_readj_range: assert property (@(posedge clk_in) disable iff (rst_in)
      readj_q[7:1] == 7'h00)
      else $error("readjust out of range");
   a_link_code: assert property (@(posedge clk_in) disable iff (rst_in)
      link_q[1:0] != DPO_LL_RSVD)
      else $error("reserved link code stored");
   a_abort_run: assert property (@(posedge clk_in) disable iff (rst_in)
      abort_run_out |-> connected_q && link_q[1:0] == DPO_LL_ABORT)
      else $error("abort run without cause");
   a_boot_once: assert property (@(posedge clk_in) disable iff (rst_in)
      boot_fire |=> boot_done_q)
      else $error("boot run not latched");
   a_retry_zero: assert property (@(posedge clk_in) disable iff (rst_in)
      safe_fail_in && retry_q == 16'h0000 && !retry_q2 |=> !retry_q2)
      else $error("retry armed with zero interval");
   a_brake_limit: assert property (@(posedge clk_in) disable iff (rst_in)
      brake_q <= `DPO_MAX_BRAKE)
      else $error("hold-off above limit");
   a_drag_limit: assert property (@(posedge clk_in) disable iff (rst_in)
      drag_q <= `DPO_MAX_DRAG)
      else $error("drag limit above range");
   a_fbpos_sign: assert property (@(posedge clk_in) disable iff (rst_in)
      fbpos_q[31] == fbpos_q[30])
      else $error("safe position not 31-bit");
   a_mid_start: assert property (@(posedge clk_in) disable iff (rst_in)
      is_mid |=> mid_pend_q)
      else $error("mid run not queued");
   a_mid_measure: assert property (@(posedge clk_in) disable iff (rst_in)
      is_mid && w16 == `DPO_CMD_FACT_SAVE_MID |=> mid_meas_q)
      else $error("mid run range wrong");
   a_no_relaunch: assert property (@(posedge clk_in) disable iff (rst_in)
      mid_q && run_end_in && !is_mid && !mid_pend_q |=> !mid_q)
      else $error("mid run kept after end");
   c_save: cover property (@(posedge clk_in) disable iff (rst_in) nv_save_out ##[1:20] nv_q == DPO_ST_DONE);
   c_mid: cover property (@(posedge clk_in) disable iff (rst_in) mid_q ##1 !mid_q);
   c_abort: cover property (@(posedge clk_in) disable iff (rst_in) abort_out);
   c_safe: cover property (@(posedge clk_in) disable iff (rst_in) safe_run_out);
endmodule
`default_nettype wire

// ===== test/dpo_master.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Fieldbus master issuing object requests
// ****************************************
module dpo_master (
   input wire logic clk_in,
   output logic wr_en_out,
   output logic rd_en_out,
   output dpo_pkg::dpo_idx_t idx_out,
   output logic [31:0] wdata_out,
   input wire logic [31:0] rdata_in,
   input wire logic ack_in,
   input wire logic abort_in
);
   import dpo_pkg::*;
   initial begin
      wr_en_out = 1'b0;
      rd_en_out = 1'b0;
      idx_out = 16'h0000;
      wdata_out = 32'h00000000;
   end
   // Index and data held until the answer is sampled
   task automatic xfer(input logic wr, input dpo_idx_t idx, input logic [31:0] data,
         output logic [33:0] ans);
      @(posedge clk_in);
      wr_en_out <= wr;
      rd_en_out <= !wr;
      idx_out <= idx;
      wdata_out <= data;
      @(posedge clk_in);
      wr_en_out <= 1'b0;
      rd_en_out <= 1'b0;
      @(negedge clk_in);
      ans = {ack_in, abort_in, rdata_in};
      // End on a rising edge so callers drive stimulus there
      @(posedge clk_in);
   endtask
   // Bounded status poll, the save window of up to 200 ms
   task automatic poll_saved(input int tries, output logic [31:0] st);
      logic [33:0] a;
      for (int i = 0; i < tries; i++) begin
         xfer(1'b0, `DPO_IDX_STORE, 32'h0, a);
         st = a[31:0];
         if (a[31:0] === 32'h0) break;
      end
   endtask
endmodule
`default_nettype wire

// ===== test/tb_drive_parameter_objects.sv
`include "dpo_map.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_drive_parameter_objects;
   import dpo_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic wr_en, rd_en, ack, abt, stand = 1'b1, run_end = 1'b0, up = 1'b0, lost = 1'b0, ops = 1'b1;
   logic sfail = 1'b0, nv_done = 1'b0, nv_err = 1'b0, brake, readj, abr, safe, mid, meas, drst, nsave;
   logic fact, user, dropp;
   dpo_idx_t idx;
   logic [31:0] wdata, rdata, tgt, st;
   logic [15:0] pdo = 16'h0014, dlim;
   int num_errors = 0, n_checks = 0, n_abr = 0, n_safe = 0, n_rst = 0, n_save = 0, n_fact = 0, n_user = 0;
   always #12.5 clk_in = ~clk_in;
   dpo_master u_master (.clk_in(clk_in), .wr_en_out(wr_en), .rd_en_out(rd_en), .idx_out(idx),
      .wdata_out(wdata), .rdata_in(rdata), .ack_in(ack), .abort_in(abt));
   dpo_objects #(.MS_CYC(10), .SEC_CYC(20)) uut (.clk_in(clk_in), .rst_in(rst_in), .wr_en_in(wr_en),
      .rd_en_in(rd_en), .idx_in(idx), .wdata_in(wdata), .rdata_out(rdata), .ack_out(ack), .abort_out(abt),
      .standstill_in(stand), .run_end_in(run_end), .link_up_in(up), .link_lost_in(lost), .op_state_in(ops),
      .pdo_ctrl_in(pdo), .safe_fail_in(sfail), .nv_done_in(nv_done), .nv_err_in(nv_err),
      .nv_boot_bad_in(1'b0), .brake_release_out(brake), .drag_limit_out(dlim), .readjust_out(readj),
      .abort_run_out(abr), .safe_run_out(safe), .safe_target_out(tgt), .mid_run_out(mid),
      .mid_run_measure_out(meas), .drive_reset_out(drst), .nv_save_out(nsave), .load_factory_out(fact),
      .load_user_out(user), .drop_pending_out(dropp));
   // Pulse outputs counted, so checks need not hit the exact cycle
   always @(posedge clk_in) begin
      n_abr += abr;
      n_safe += safe;
      n_rst += drst;
      n_save += nsave;
      n_fact += fact;
      n_user += user;
   end
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wo(input dpo_idx_t i, input logic [31:0] d, input logic ab);
      logic [33:0] a;
      u_master.xfer(1'b1, i, d, a);
      check({32'h0, a[33:32]}, {32'h0, ab ? 2'b01 : 2'b10});
   endtask
   task automatic ro(input dpo_idx_t i, input logic [31:0] e);
      logic [33:0] a;
      u_master.xfer(1'b0, i, 32'h0, a);
      check(a, {2'b10, e});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_boot();
      ro(`DPO_IDX_STORE, 32'h0);
      ro(`DPO_IDX_BRAKE, 32'd1000);
      ro(`DPO_IDX_DRAG, 32'd4);
      ro(`DPO_IDX_READJ, 32'd0);
      ro(`DPO_IDX_LINK, 32'd1);
      ro(`DPO_IDX_FBPOS, 32'd0);
      ro(`DPO_IDX_RETRY, 32'd0);
      check(dlim, 16'd4);
      wo(`DPO_IDX_LINK, 32'h6, 1'b0);
      cyc(240);
      check(n_safe, 0);
      cyc(70);
      check(n_safe, 1);
      check(tgt, 32'h0);
      up <= 1'b1;
   endtask
   task automatic t_limits();
      wo(`DPO_IDX_BRAKE, 32'd3000, 1'b0);
      wo(`DPO_IDX_BRAKE, 32'd3001, 1'b1);
      ro(`DPO_IDX_BRAKE, 32'd3000);
      wo(`DPO_IDX_DRAG, 32'd10, 1'b0);
      check(dlim, 16'd10);
      wo(`DPO_IDX_DRAG, 32'd11, 1'b1);
      stand <= 1'b0;
      wo(`DPO_IDX_DRAG, 32'd3, 1'b1);
      wo(`DPO_IDX_STORE, 32'h1, 1'b1);
      stand <= 1'b1;
      ro(`DPO_IDX_DRAG, 32'd10);
      wo(`DPO_IDX_READJ, 32'd2, 1'b1);
      wo(`DPO_IDX_READJ, 32'd1, 1'b0);
      check(readj, 1'b1);
      wo(`DPO_IDX_LINK, 32'h7, 1'b1);
      ro(`DPO_IDX_LINK, 32'h6);
      wo(`DPO_IDX_FWREV, 32'h5, 1'b1);
      wo(`DPO_IDX_MODEL, 32'h5, 1'b1);
      wo(`DPO_IDX_FBPOS, 32'h80000000, 1'b1);
      wo(`DPO_IDX_STORE, 32'h0, 1'b1);
      wo(`DPO_IDX_STORE, 32'h2, 1'b1);
   endtask
   task automatic t_link();
      wo(`DPO_IDX_FBPOS, 32'hfffffff0, 1'b0);
      wo(`DPO_IDX_LINK, 32'h1, 1'b0);
      lost <= 1'b1;
      cyc(1);
      lost <= 1'b0;
      cyc(3);
      check(n_abr, 1);
      wo(`DPO_IDX_LINK, 32'h2, 1'b0);
      lost <= 1'b1;
      cyc(1);
      lost <= 1'b0;
      cyc(3);
      check(n_safe, 2);
      check(tgt, 32'hfffffff0);
      wo(`DPO_IDX_RETRY, 32'd1, 1'b0);
      for (int r = 1; r >= 0; r--) begin
         sfail <= 1'b1;
         cyc(1);
         sfail <= 1'b0;
         cyc(28);
         check(n_safe, 2 + 1);
         if (r == 1) wo(`DPO_IDX_RETRY, 32'd0, 1'b0);
      end
   endtask
   task automatic t_brake();
      wo(`DPO_IDX_BRAKE, 32'd2, 1'b0);
      run_end <= 1'b1;
      cyc(1);
      run_end <= 1'b0;
      cyc(12);
      check(brake, 1'b1);
      cyc(14);
      check(brake, 1'b0);
   endtask
   task automatic t_save();
      wo(`DPO_IDX_STORE, 32'h1, 1'b0);
      check(n_save, 1);
      ro(`DPO_IDX_STORE, 32'h1);
      nv_done <= 1'b1;
      cyc(1);
      nv_done <= 1'b0;
      u_master.poll_saved(4, st);
      check(st, 32'h0);
      wo(`DPO_IDX_STORE, 32'h1, 1'b0);
      nv_err <= 1'b1;
      cyc(1);
      nv_err <= 1'b0;
      ro(`DPO_IDX_STORE, 32'h2);
   endtask
   task automatic t_cmds();
      wo(`DPO_IDX_STORE, `DPO_CMD_RESET, 1'b0);
      check(n_rst, 1);
      wo(`DPO_IDX_STORE, `DPO_CMD_FACT, 1'b0);
      check(n_fact, 1);
      check(n_save, 2);
      ro(`DPO_IDX_BRAKE, 32'd1000);
      wo(`DPO_IDX_STORE, `DPO_CMD_USER, 1'b0);
      check(n_user, 1);
      check(n_save, 2);
      wo(`DPO_IDX_STORE, `DPO_CMD_FACT_SAVE, 1'b0);
      check(n_fact, 2);
      check(n_save, 3);
      nv_done <= 1'b1;
      cyc(1);
      nv_done <= 1'b0;
      cyc(4);
      check(mid, 1'b0);
   endtask
   task automatic t_mid();
      wo(`DPO_IDX_STORE, `DPO_CMD_USER_MID, 1'b0);
      cyc(3);
      check({mid, dropp, meas}, 3'b110);
      check(n_user, 2);
      cyc(3);
      check(mid, 1'b1);
      pdo <= 16'h0015;
      cyc(2);
      check(mid, 1'b0);
      wo(`DPO_IDX_STORE, `DPO_CMD_USER_MID, 1'b0);
      cyc(3);
      wo(`DPO_IDX_CTRL, 32'h0, 1'b0);
      cyc(1);
      check(mid, 1'b0);
      wo(`DPO_IDX_STORE, `DPO_CMD_FACT_SAVE_MID, 1'b0);
      check(n_fact, 3);
      check(n_save, 4);
      nv_done <= 1'b1;
      cyc(1);
      nv_done <= 1'b0;
      cyc(2);
      check({mid, meas}, 2'b11);
      run_end <= 1'b1;
      cyc(1);
      run_end <= 1'b0;
      cyc(4);
      check(mid, 1'b0);
   endtask
   initial begin
      cyc(2);
      rst_in <= 1'b0;
      t_boot();
      t_limits();
      t_link();
      t_brake();
      t_save();
      t_cmds();
      t_mid();
      final_report();
   end
   // Run takes about 570 cycles; limit set well above that
   initial begin
      #(25 * 6000);
      num_errors++;
      final_report();
   end
endmodule
`default_nettype wire
